//--- dv/eqs_far_model.sv
// Egress transmitter model that takes, stalls or randomly throttles descriptors.
`timescale 1ns/1ps
module eqs_far_model (
  // Clock and behaviour select: 0 always ready, 1 stalled, 2 random.
  input wire logic clock_i,
  input wire logic [1:0] mode_i,
  // Egress handshake.
  input wire logic out_valid_i,
  output logic out_ready_o
);
  integer seed = 32'hc8e3a46d;
  initial out_ready_o = 1'b0;
  // Ready is a level that may drop while a word waits, as a real transmitter's can.
  always @(posedge clock_i) begin
    if (mode_i == 2'h0)
      out_ready_o <= 1'b1;
    else if (mode_i == 2'h1)
      out_ready_o <= 1'b0;
    else
      out_ready_o <= out_valid_i & 1'($random(seed));
  end
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the egress QoS classifier and scheduler.
`timescale 1ns/1ps
module tb_top;
  import eqs_pkg::*;
  logic clock_i = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [2:0] in_port = 3'h0;
  logic in_tagged = 1'b0;
  logic [2:0] in_prio = 3'h0;
  logic [15:0] in_desc = 16'h0;
  logic out_valid;
  logic out_ready;
  logic [15:0] out_desc;
  logic [1:0] out_queue;
  logic [1:0] far_mode = 2'h1;
  logic ce = 1'b1;
  integer seed = 32'hc8e3a46d;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] seq = 16'h0;
  logic [15:0] pq[4][$];
  logic [17:0] note_q[$];
  logic [31:0] rd;
  logic [15:0] map_v;
  logic [31:0] port_v;

  initial forever #2.5 clock_i = ~clock_i;

  eqs_sched #(.DESC_W(16), .Q_DEPTH(8)) i_eqs_sched (
    .clock_i(clock_i), .ce_i(ce), .rst_b_i(rst_b),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(HSIZE_WORD), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .in_port_i(in_port),
    .in_tagged_i(in_tagged), .in_prio_i(in_prio), .in_desc_i(in_desc),
    .out_valid_o(out_valid), .out_ready_i(out_ready), .out_desc_o(out_desc),
    .out_queue_o(out_queue)
  );

  eqs_far_model i_eqs_far_model (
    .clock_i(clock_i), .mode_i(far_mode), .out_valid_i(out_valid), .out_ready_o(out_ready)
  );

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One AHB-Lite single word transfer; read data lands in rd.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Valid is left high so back-to-back descriptors never toggle it in one step.
  task send(input logic tg, input logic [2:0] pr, input logic [2:0] pt, input logic [1:0] eq,
            input bit fcfs);
    in_valid <= 1'b1;
    in_tagged <= tg;
    in_prio <= pr;
    in_port <= pt;
    in_desc <= seq;
    if (fcfs)
      note_q.push_back({eq, seq});
    else
      pq[eq].push_back(seq);
    seq = seq + 16'h1;
    do @(posedge clock_i); while (in_ready !== 1'b1);
  endtask

  // Tagged descriptor whose priority the default map sends to queue q.
  task sendq(input logic [1:0] q);
    send(1'b1, {~q, 1'($random(seed))}, 3'($random(seed)), q, 1'b0);
  endtask

  task idle(input int n);
    in_valid <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask

  // Works out the departure order of the loaded queues for strict or weighted service.
  task plan(input bit strict, input logic [31:0] w);
    int q;
    int n;
    q = 0;
    while (pq[0].size() + pq[1].size() + pq[2].size() + pq[3].size() > 0) begin
      if (strict) begin
        q = 0;
        while (pq[q].size() == 0) q++;
        note_q.push_back({2'(q), pq[q].pop_front()});
      end else begin
        n = int'(w[8*q+:8]);
        while (n > 0 && pq[q].size() > 0) begin
          note_q.push_back({2'(q), pq[q].pop_front()});
          n--;
        end
        q = (q + 1) % 4;
      end
    end
  endtask

  task drain;
    int k;
    k = 0;
    while (note_q.size() > 0 && k < 3000) begin
      @(posedge clock_i);
      k++;
    end
    chk("pending", 32'h0, note_q.size());
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (rst_b === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (note_q.size() == 0)
        chk("surplus", 32'h0, 32'h1);
      else
        chk("egress", {14'h0, note_q.pop_front()}, {14'h0, out_queue, out_desc});
    end
    if (cycles == 30000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    int i;
    logic tg;
    logic [2:0] pr;
    logic [2:0] pt;
    logic [2:0] pe;
    repeat (5) @(posedge clock_i);
    rst_b <= 1'b1;
    @(posedge clock_i);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("mode", {30'h0, MODE_WRR}, {30'h0, rd[1:0]});
    bus(1'b0, ADDR_WEIGHT, 32'h0);
    chk("weights", 32'h0102_0408, rd);
    bus(1'b0, ADDR_MAP, 32'h0);
    chk("map", 32'h0000_05AF, rd);
    bus(1'b0, ADDR_PORT, 32'h0);
    chk("ports", 32'h0, rd);
    bus(1'b1, 8'h24, 32'hFFFF_FFFF);
    bus(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Weighted service from reset; the highest queue is loaded first and kept busy.
    repeat (4) sendq(2'h0);
    idle(10);
    repeat (2) sendq(2'h3);
    repeat (3) sendq(2'h2);
    repeat (5) sendq(2'h1);
    repeat (5) sendq(2'h0);
    idle(1);
    plan(1'b0, 32'h0102_0408);
    far_mode <= 2'h0;
    drain();
    bus(1'b1, ADDR_WEIGHT, 32'h0305_0709);
    bus(1'b0, ADDR_WEIGHT, 32'h0);
    chk("weights", 32'h0305_0709, rd);
    // Strict priority with the highest queue arriving before the others.
    far_mode <= 2'h1;
    bus(1'b1, ADDR_CTRL, {30'h0, MODE_STRICT});
    repeat (4) sendq(2'h0);
    idle(10);
    repeat (2) sendq(2'h3);
    sendq(2'h2);
    repeat (2) sendq(2'h1);
    sendq(2'h0);
    idle(1);
    plan(1'b1, 32'h0);
    far_mode <= 2'h0;
    drain();
    // The new weights now govern service: nine from the highest queue, three from the lowest.
    bus(1'b1, ADDR_CTRL, {30'h0, MODE_WRR});
    far_mode <= 2'h1;
    repeat (4) sendq(2'h0);
    idle(10);
    repeat (2) sendq(2'h1);
    repeat (4) sendq(2'h3);
    sendq(2'h2);
    repeat (5) sendq(2'h0);
    idle(1);
    plan(1'b0, 32'h0305_0709);
    far_mode <= 2'h0;
    drain();
    // Arrival order with random classification and a throttling transmitter.
    map_v = 16'($random(seed));
    port_v = $random(seed);
    bus(1'b1, ADDR_MAP, {16'h0, map_v});
    bus(1'b1, ADDR_PORT, port_v);
    bus(1'b1, ADDR_CTRL, {30'h0, MODE_FCFS});
    far_mode <= 2'h2;
    for (i = 0; i < 40; i++) begin
      tg = 1'($random(seed));
      pr = 3'($random(seed));
      pt = 3'($random(seed));
      pe = tg ? pr : (port_v[4*pt+3] ? port_v[4*pt+:3] : 3'h0);
      send(tg, pr, pt, map_v[2*pe+:2], 1'b1);
      if (i % 9 == 8)
        idle(3);
    end
    idle(1);
    drain();
    bus(1'b1, ADDR_STATUS, 32'hFFFF_FFFF);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    // A write offered while the enable is low must leave the mode untouched.
    ce <= 1'b0;
    bus(1'b1, ADDR_CTRL, {30'h0, MODE_STRICT});
    ce <= 1'b1;
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("frozen", {30'h0, MODE_FCFS}, {30'h0, rd[1:0]});
    summarize();
  end
endmodule

//--- rtl/eqs_buf.sv
// Two-entry output buffer with valid and ready on both sides.
`timescale 1ns/1ps
module eqs_buf #(
  parameter int W = 18
) (
  // Clock and control.
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Filling side.
  input wire logic s_valid_i,
  output logic s_ready_o,
  input wire logic [W-1:0] s_data_i,
  // Draining side.
  output logic m_valid_o,
  input wire logic m_ready_i,
  output logic [W-1:0] m_data_o
);
  logic spare_valid;
  logic [W-1:0] spare_data;

  // The spare entry catches the word accepted while the head stalls.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      m_valid_o <= 1'b0;
      spare_valid <= 1'b0;
    end else if (ce_i) begin
      if (m_ready_i || !m_valid_o) begin
        if (spare_valid) begin
          m_valid_o <= 1'b1;
          spare_valid <= 1'b0;
        end else begin
          m_valid_o <= s_valid_i && s_ready_o;
        end
      end else if (s_valid_i && s_ready_o) begin
        spare_valid <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i) begin
      if (m_ready_i || !m_valid_o) begin
        m_data_o <= spare_valid ? spare_data : s_data_i;
      end else if (s_valid_i && s_ready_o) begin
        spare_data <= s_data_i;
      end
    end
  end

  assign s_ready_o = !spare_valid;

  sequence s_stall;
    m_valid_o && !m_ready_i;
  endsequence

  property p_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      s_stall |=> m_valid_o && $stable(m_data_o);
  endproperty
  a_hold: assert property (p_hold) else $error("Stalled word changed or vanished."); // R1

  property p_full_refuses;
    @(posedge clock_i) disable iff (!rst_b_i)
      (s_stall and (ce_i && s_valid_i && s_ready_o)) |=> !s_ready_o;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("Full buffer still ready."); // R1
endmodule

//--- rtl/eqs_pkg.sv
// Register map, field layout and reset values of the egress QoS scheduler.
package eqs_pkg;
  localparam int NUM_Q = 4;
  localparam int NUM_PORT = 8;
  localparam int PRIO_W = 3;
  localparam int QSEL_W = 2;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WEIGHT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MAP = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_PORT = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam logic [1:0] MODE_FCFS = 2'h0;
  localparam logic [1:0] MODE_STRICT = 2'h1;
  localparam logic [1:0] MODE_WRR = 2'h2;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MODE_W = 2;
  localparam int WGT_W = 8;
  localparam int MAP_W = 2;
  localparam int PORT_W = 4;
  localparam int PORT_EN_BIT = 3;
  localparam int STAT_W = 8;
  localparam logic [1:0] RST_MODE = MODE_WRR;
  localparam logic [31:0] RST_WEIGHT = 32'h0102_0408;
  localparam logic [15:0] RST_MAP = 16'h05AF;
  localparam logic [31:0] RST_PORT = 32'h0000_0000;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

//--- rtl/eqs_sched.sv
// Egress QoS classifier and four-queue transmit scheduler with AHB-Lite registers.
// What this block does
// R1 - Keep four queues, highest to lowest, and send by the selected mode.
// R2 - First-come mode sends packets in arrival order, ignoring queue priority.
// R3 - Strict mode never serves a queue while a higher queue holds packets.
// R4 - Round robin sends up to each weight per queue, highest queue first, descending.
// R5 - Reset selects round robin with weights eight, four, two and one.
// R6 - Each of the four weights is set on its own.
// R7 - A tagged frame picks its queue by its tag priority through the map.
// R8 - An untagged frame uses the ingress priority of its receiving port.
// R9 - Eight priority levels, three bits, each mapped freely to any queue.
// R10 - Default map: 0-1 lowest, 2-3 second low, 4-5 second high, 6-7 highest.
// R11 - A port priority goes through the same map as a tag priority.
// R12 - Each port priority is disabled or a value from zero to seven.
// R13 - Round robin skips an emptied queue to the next non-empty one at once.
// R14 - Untagged frames on a port with priority disabled count as priority zero.
//
// Added by the designer: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module eqs_sched
  import eqs_pkg::*;
#(
  parameter int DESC_W = 16,
  parameter int Q_DEPTH = 4
) (
  // Clock, enable and reset.
  input wire logic clock_i,
  input wire logic ce_i,
  input wire logic rst_b_i,
  // AHB-Lite slave.
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Ingress descriptors from the forwarding logic.
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [2:0] in_port_i,
  input wire logic in_tagged_i,
  input wire logic [PRIO_W-1:0] in_prio_i,
  input wire logic [DESC_W-1:0] in_desc_i,
  // Egress descriptors to the port transmitter.
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [DESC_W-1:0] out_desc_o,
  output logic [QSEL_W-1:0] out_queue_o
);
  localparam int PTR_W = $clog2(Q_DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam int SEQ_W = $clog2(NUM_Q * Q_DEPTH) + 1;

  // Configuration and its next values; reads see the next value so that a
  // read right behind a write returns the new contents.
  logic [CTRL_MODE_W-1:0] mode;
  logic [31:0] weight_reg;
  logic [15:0] map_reg;
  logic [31:0] port_reg;
  logic [CTRL_MODE_W-1:0] next_mode;
  logic [31:0] next_weight;
  logic [15:0] next_map;
  logic [31:0] next_port;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] rd_val;

  // Queue state.
  logic [NUM_Q-1:0] q_ne;
  logic [CNT_W-1:0] q_cnt [NUM_Q];
  logic [CNT_W-1:0] next_cnt [NUM_Q];
  logic [SEQ_W-1:0] q_age [NUM_Q];
  logic [DESC_W-1:0] q_head [NUM_Q];
  logic [SEQ_W-1:0] seq;

  // Classification.
  logic [PORT_W-1:0] port_cfg;
  logic [PRIO_W-1:0] eff_prio;
  logic [QSEL_W-1:0] push_q;
  logic push;

  // Scheduling.
  logic [QSEL_W-1:0] st_sel;
  logic [QSEL_W-1:0] fc_sel;
  logic [QSEL_W-1:0] wr_sel;
  logic [QSEL_W-1:0] idx;
  logic [QSEL_W-1:0] sel;
  logic st_found;
  logic fc_found;
  logic wr_found;
  logic found;
  logic pop;
  logic [QSEL_W-1:0] wrr_cur;
  logic [WGT_W-1:0] wrr_left;
  logic buf_ready;

  // AHB-Lite: zero wait states, always OKAY.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce_i && hready_i) begin
      wr_pend <= hsel_i && htrans_i[1] && hwrite_i && hsize_i == HSIZE_WORD;
      wr_addr <= haddr_i[ADDR_W-1:0];
    end
  end

  always_comb begin
    next_mode = mode;
    next_weight = weight_reg;
    next_map = map_reg;
    next_port = port_reg;
    if (wr_pend) begin
      case (wr_addr)
        ADDR_CTRL: next_mode = hwdata_i[CTRL_MODE_LSB +: CTRL_MODE_W];
        ADDR_WEIGHT: next_weight = hwdata_i; // R6
        ADDR_MAP: next_map = hwdata_i[15:0]; // R9
        ADDR_PORT: next_port = hwdata_i; // R12
        default: next_mode = mode;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      mode <= RST_MODE; // R5
      weight_reg <= RST_WEIGHT; // R5
      map_reg <= RST_MAP; // R10
      port_reg <= RST_PORT;
    end else if (ce_i) begin
      mode <= next_mode;
      weight_reg <= next_weight;
      map_reg <= next_map;
      port_reg <= next_port;
    end
  end

  // Unmapped offsets read as zero and ignore writes.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr_i[ADDR_W-1:0])
      ADDR_CTRL: rd_val[CTRL_MODE_LSB +: CTRL_MODE_W] = next_mode;
      ADDR_WEIGHT: rd_val = next_weight;
      ADDR_MAP: rd_val[15:0] = next_map;
      ADDR_PORT: rd_val = next_port;
      ADDR_STATUS: begin
        for (int i = 0; i < NUM_Q; i++) begin
          rd_val[i*STAT_W +: STAT_W] = STAT_W'(q_cnt[i]);
        end
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (ce_i && hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      hrdata_o <= rd_val;
    end
  end

  // Tagged frames use their tag, untagged ones their port's setting, and a
  // disabled port falls back to zero; all go through the one map.
  assign port_cfg = port_reg[{in_port_i, 2'b00} +: PORT_W];
  assign eff_prio = in_tagged_i ? in_prio_i : // R7
    (port_cfg[PORT_EN_BIT] ? port_cfg[PRIO_W-1:0] : 3'h0); // R8 R12 R14
  assign push_q = map_reg[{eff_prio, 1'b0} +: MAP_W]; // R11
  assign push = ce_i && in_valid_i && in_ready_o;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      seq <= '0;
    end else if (push) begin
      seq <= seq + 1'b1;
    end
  end

  // Each queue stamps its entries with an arrival number for first-come order.
  for (genvar g = 0; g < NUM_Q; g++) begin : g_q
    logic [SEQ_W+DESC_W-1:0] mem [Q_DEPTH];
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic do_push;
    logic do_pop;
    assign do_push = push && push_q == QSEL_W'(g); // R1
    assign do_pop = pop && sel == QSEL_W'(g);
    always_ff @(posedge clock_i) begin
      if (do_push) begin
        mem[wp] <= {seq, in_desc_i};
      end
    end
    always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
        wp <= '0;
        rp <= '0;
        q_cnt[g] <= '0;
      end else if (ce_i) begin
        if (do_push) begin
          wp <= wp + 1'b1;
        end
        if (do_pop) begin
          rp <= rp + 1'b1;
        end
        q_cnt[g] <= next_cnt[g];
      end
    end
    assign next_cnt[g] = q_cnt[g] + CNT_W'(do_push) - CNT_W'(do_pop);
    assign q_ne[g] = q_cnt[g] != '0;
    assign q_head[g] = mem[rp][DESC_W-1:0];
    assign q_age[g] = seq - mem[rp][SEQ_W+DESC_W-1:DESC_W];
  end

  // Ready is taken from the counts that the queues will hold next cycle.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      in_ready_o <= 1'b1;
    end else if (ce_i) begin
      in_ready_o <= 1'b1;
      for (int i = 0; i < NUM_Q; i++) begin
        if (next_cnt[i] >= CNT_W'(Q_DEPTH)) begin
          in_ready_o <= 1'b0;
        end
      end
    end
  end

  // Candidate queue for each mode.
  always_comb begin
    st_sel = '0;
    st_found = 1'b0;
    fc_sel = '0;
    fc_found = 1'b0;
    wr_sel = wrr_cur;
    wr_found = 1'b0;
    idx = '0;
    for (int i = NUM_Q - 1; i >= 0; i--) begin
      if (q_ne[i]) begin
        st_sel = QSEL_W'(i); // R3
        st_found = 1'b1;
      end
    end
    for (int i = 0; i < NUM_Q; i++) begin
      if (q_ne[i] && (!fc_found || q_age[i] > q_age[fc_sel])) begin
        fc_sel = QSEL_W'(i); // R2
        fc_found = 1'b1;
      end
    end
    if (q_ne[wrr_cur] && wrr_left != '0) begin
      wr_found = 1'b1; // R4
    end else begin
      // A queue of weight zero is never switched to in this mode.
      for (int k = 1; k <= NUM_Q; k++) begin
        idx = wrr_cur + QSEL_W'(k);
        if (!wr_found && q_ne[idx] && weight_reg[{idx, 3'b000} +: WGT_W] != '0) begin
          wr_sel = idx; // R13
          wr_found = 1'b1;
        end
      end
    end
  end

  always_comb begin
    case (mode)
      MODE_FCFS: begin
        sel = fc_sel;
        found = fc_found;
      end
      MODE_STRICT: begin
        sel = st_sel;
        found = st_found;
      end
      default: begin
        sel = wr_sel;
        found = wr_found;
      end
    endcase
  end

  assign pop = ce_i && found && buf_ready;

  // Credit of the current round robin queue.
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wrr_cur <= '0;
      wrr_left <= RST_WEIGHT[WGT_W-1:0];
    end else if (pop && mode != MODE_FCFS && mode != MODE_STRICT) begin
      if (sel == wrr_cur && wrr_left != '0) begin
        wrr_left <= wrr_left - 1'b1; // R4
      end else begin
        wrr_cur <= sel;
        wrr_left <= weight_reg[{sel, 3'b000} +: WGT_W] - 1'b1; // R4 R13
      end
    end
  end

  eqs_buf #(
    .W(QSEL_W + DESC_W)
  ) u_buf (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .s_valid_i(pop),
    .s_ready_o(buf_ready),
    .s_data_i({sel, q_head[sel]}),
    .m_valid_o(out_valid_o),
    .m_ready_i(out_ready_i),
    .m_data_o({out_queue_o, out_desc_o})
  );

  property p_strict;
    @(posedge clock_i) disable iff (!rst_b_i)
      (pop && mode == MODE_STRICT) |-> (q_ne & ((4'h1 << sel) - 4'h1)) == 4'h0;
  endproperty
  a_strict: assert property (p_strict) else $error("Strict mode skipped a higher queue."); // R3
  property p_fcfs;
    @(posedge clock_i) disable iff (!rst_b_i)
      (pop && mode == MODE_FCFS) |-> q_age[sel] >= q_age[0] || !q_ne[0];
  endproperty
  a_fcfs: assert property (p_fcfs) else $error("First-come mode passed an older packet."); // R2
  property p_tagged;
    @(posedge clock_i) disable iff (!rst_b_i)
      (push && in_tagged_i) |=> q_cnt[map_reg[{$past(in_prio_i), 1'b0} +: 2]] != '0;
  endproperty
  a_tagged: assert property (p_tagged) else $error("Tagged frame not queued by map."); // R7
  property p_untag_off;
    @(posedge clock_i) disable iff (!rst_b_i)
      (push && !in_tagged_i && !port_cfg[PORT_EN_BIT]) |-> push_q == map_reg[1:0];
  endproperty
  a_untag_off: assert property (p_untag_off) else $error("Disabled port not priority zero."); // R14
  sequence s_reset_done;
    $past(!rst_b_i) && rst_b_i;
  endsequence
  property p_reset_wrr;
    @(posedge clock_i) disable iff (!rst_b_i)
      s_reset_done |-> mode == MODE_WRR && weight_reg == 32'h0102_0408 && map_reg == 16'h05AF;
  endproperty
  a_reset_wrr: assert property (p_reset_wrr) else $error("Wrong settings after reset."); // R5
  sequence s_wrr_switch;
    pop && mode == MODE_WRR && sel != wrr_cur;
  endsequence
  // The reload uses the weight seen at the pop, even if a write lands on that edge.
  property p_wrr_reload;
    @(posedge clock_i) disable iff (!rst_b_i)
      s_wrr_switch |=> wrr_cur == $past(sel) &&
        wrr_left == WGT_W'($past(weight_reg) >> {wrr_cur, 3'b000}) - 8'h01;
  endproperty
  a_wrr_reload: assert property (p_wrr_reload) else $error("Round robin credit not reloaded."); // R4
  property p_no_idle;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ce_i && buf_ready && mode == MODE_WRR && (q_ne & {weight_reg[24 +: 8] != 8'h00,
        weight_reg[16 +: 8] != 8'h00, weight_reg[8 +: 8] != 8'h00,
        weight_reg[0 +: 8] != 8'h00}) != 4'h0) |-> pop;
  endproperty
  a_no_idle: assert property (p_no_idle) else $error("Round robin idled with work queued."); // R13
  property p_bound;
    @(posedge clock_i) disable iff (!rst_b_i)
      push |=> q_cnt[$past(push_q)] <= CNT_W'(Q_DEPTH);
  endproperty
  a_bound: assert property (p_bound) else $error("Queue overfilled."); // R1
endmodule
